/* inc/ougc_pkg.sv */
`default_nettype none
package ougc_pkg;
  // Address map geometry
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned NUM_CHAN      = 8;
  localparam int unsigned CODE_W        = 3;
  localparam int unsigned SRC_W         = 4;
  localparam int unsigned LEGACY_REGS   = 8;
  // Global window base and register offsets
  localparam logic [7:0] OFS_SUMMARY    = 8'h80;
  localparam logic [7:0] OFS_CODES_LOW  = 8'h81;
  localparam logic [7:0] OFS_CODES_MID  = 8'h82;
  localparam logic [7:0] OFS_CODES_HIGH = 8'h83;
  localparam logic [7:0] OFS_TIMER_CMD  = 8'h84;
  localparam logic [7:0] OFS_TIMER_RSVD = 8'h85;
  localparam logic [7:0] OFS_TIMER_LOW  = 8'h86;
  localparam logic [7:0] OFS_TIMER_HIGH = 8'h87;
  localparam logic [7:0] OFS_SAMPLE_8X  = 8'h88;
  localparam logic [7:0] OFS_SAMPLE_4X  = 8'h89;
  localparam logic [7:0] OFS_SOFT_RST   = 8'h8A;
  localparam logic [7:0] OFS_SLEEP_EN   = 8'h8B;
  localparam logic [7:0] OFS_REVISION   = 8'h8C;
  localparam logic [7:0] OFS_PART_ID    = 8'h8D;
  localparam logic [7:0] OFS_BCAST      = 8'h8E;
  // Offset of the interrupt status register inside a channel window
  localparam logic [3:0] CH_OFS_IRQ_STATUS = 4'h2;
  // Reset values, all-asleep sleep enable pattern and timer pending read value
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_COUNT     = 16'h0000;
  localparam logic [7:0]  SLEEP_ALL     = 8'hFF;
  localparam logic [7:0]  TIMER_PEND_RD = 8'h01;
  // Source codes
  localparam logic [2:0] CODE_NONE      = 3'h0;
  localparam logic [2:0] CODE_RX        = 3'h1;
  localparam logic [2:0] CODE_RX_TMO    = 3'h2;
  localparam logic [2:0] CODE_TX_EMPTY  = 3'h3;
  localparam logic [2:0] CODE_MODEM     = 3'h4;
  localparam logic [2:0] CODE_TIMER     = 3'h7;
  // Source vector bit positions from a channel core
  localparam int unsigned SRC_RX        = 0;
  localparam int unsigned SRC_RX_TMO    = 1;
  localparam int unsigned SRC_TX_EMPTY  = 2;
  localparam int unsigned SRC_MODEM     = 3;
  // Timer commands
  localparam logic [3:0] TCMD_IRQ_ON    = 4'h1;
  localparam logic [3:0] TCMD_IRQ_OFF   = 4'h2;
endpackage : ougc_pkg
`default_nettype wire

/* rtl/ougc_regs.sv */
// Behaviour
// - Decode 8-bit address into 256-byte space
// - Channel n owns 16 bytes at n*16
// - Low eight channel registers stay legacy compatible
// - Global registers at 0x80-0x8F, no banking
// - Summary register: bit n set when channel pending
// - Summary clears when servicing register is read
// - Three registers pack 3-bit codes contiguously
// - Summary and code registers reset to zero
// - Channel contributions gated by channel interrupt enables
// - Timer masked by command, wake-up by sleep enable
// - Wake-up interrupt only after all eight slept
// - Timer command, reserved byte, count low/high
// - Per-channel 8x/4x select, otherwise 16x sampling
// - Write-only soft reset, bit n resets channel
// - Read/write sleep enable, bit per channel
// - Bit 0 broadcasts channel writes to all
// - Fixed revision and identification, writes ignored
// - Codes: none, rx, timeout, tx, modem, reserved
// - Code 111 timer only on channel 0, cleared by read
// - Timer command reads 0x01 while timer pending
`default_nettype none
module ougc_regs #(
  parameter int unsigned       NUM_CHAN = 8,      // Channel count, only 8 is served
  parameter logic [7:0]        REVISION = 8'h01,  // Arbitrary revision value
  parameter logic [7:0]        PART_ID  = 8'h5A   // Arbitrary identification value
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  // Host parallel bus
  input  wire logic                   hostCs,
  input  wire logic                   hostRd,
  input  wire logic                   hostWr,
  input  wire logic [7:0]             hostAddr,
  input  wire logic [7:0]             hostWrData,
  output logic      [7:0]             hostRdData,
  // Channel core access
  output logic      [3:0]             chanOffset,
  output logic      [7:0]             chanWrData,
  output logic      [NUM_CHAN-1:0]    chanWrStrobe,
  output logic      [NUM_CHAN-1:0]    chanRdStrobe,
  input  wire logic [NUM_CHAN*8-1:0]  chanRdData,
  // Channel interrupt state
  input  wire logic [NUM_CHAN*4-1:0]  chanSrcPend,
  input  wire logic [NUM_CHAN*4-1:0]  chanSrcEnable,
  input  wire logic [NUM_CHAN-1:0]    chanAsleep,
  input  wire logic [NUM_CHAN-1:0]    chanWake,
  // Channel controls
  output logic      [NUM_CHAN-1:0]    chanSample8x,
  output logic      [NUM_CHAN-1:0]    chanSample4x,
  output logic      [NUM_CHAN-1:0]    chanSample16x,
  output logic      [NUM_CHAN-1:0]    chanSoftReset,
  output logic      [NUM_CHAN-1:0]    chanSleepEnable,
  // Timer engine
  output logic      [3:0]             timerCmd,
  output logic                        timerCmdValid,
  output logic      [15:0]            timerCount,
  input  wire logic                   timerTimeout
);

  // Field layout assumes exactly eight channels of 16 bytes
  if (NUM_CHAN != ougc_pkg::NUM_CHAN) begin : gChanCheck
    $error("ougc_regs serves exactly eight channels");
  end

  // Bus qualifiers
  wire logic       rdTake;                    // Read access this cycle
  wire logic       wrTake;                    // Write access this cycle
  wire logic       chanHit;                   // Address in channel space
  wire logic       globHit;                   // Address in global window
  wire logic [2:0] chanIdx;                   // Selected channel
  wire logic [NUM_CHAN-1:0] chanOneHot;       // Channel select one-hot

  assign rdTake  = hostCs & hostRd;
  assign wrTake  = hostCs & hostWr;
  // Upper half split: A7 low is channels, A7 high with A6:A4 zero is global
  assign chanHit = ~hostAddr[7];
  assign globHit = hostAddr[7] & (hostAddr[6:4] == 3'h0);
  assign chanIdx = hostAddr[6:4];
  assign chanOneHot = 8'h01 << chanIdx;

  // Control, interrupt state and read return registers
  logic [7:0]  sample8x_reg;                  // 8x select per channel
  logic [7:0]  sample8x_next;
  logic [7:0]  sample4x_reg;                  // 4x select per channel
  logic [7:0]  sample4x_next;
  logic [7:0]  sleepEn_reg;                   // Sleep enable per channel
  logic [7:0]  sleepEn_next;
  logic        bcast_reg;                     // Broadcast write enable
  logic        bcast_next;
  logic [15:0] count_reg;                     // Timer reload value
  logic [15:0] count_next;
  logic [7:0]  softRst_reg;                   // One-cycle reset pulses
  logic [7:0]  softRst_next;
  logic [3:0]  tCmd_reg;                      // Last command issued
  logic [3:0]  tCmd_next;
  logic        tCmdValid_reg;                 // Command strobe
  logic        tCmdValid_next;
  logic        timerIrqEn_reg;                // Timer interrupt mask
  logic        timerIrqEn_next;
  logic        timerPend_reg;                 // Timer interrupt pending
  logic        timerPend_next;
  logic        allSlept_reg;                  // Every channel had slept
  logic        allSlept_next;
  logic [7:0]  wakePend_reg;                  // Wake-up indicator per channel
  logic [7:0]  wakePend_next;
  logic [7:0]  summary_reg;                   // Channel summary image
  logic [7:0]  summary_next;
  logic [23:0] codes_reg;                     // Packed source codes
  logic [23:0] codes_next;
  logic [7:0]  rdData_reg;                    // Host read return
  logic [7:0]  rdData_next;

  // Global register write decode and timer command read decode
  wire logic wr8x;
  wire logic wr4x;
  wire logic wrSleep;
  wire logic wrBcast;
  wire logic wrCntLow;
  wire logic wrCntHigh;
  wire logic wrSoftRst;
  wire logic wrTimerCmd;
  wire logic rdTimerCmd;

  assign wr8x       = wrTake & globHit & (hostAddr == ougc_pkg::OFS_SAMPLE_8X);
  assign wr4x       = wrTake & globHit & (hostAddr == ougc_pkg::OFS_SAMPLE_4X);
  assign wrSleep    = wrTake & globHit & (hostAddr == ougc_pkg::OFS_SLEEP_EN);
  assign wrBcast    = wrTake & globHit & (hostAddr == ougc_pkg::OFS_BCAST);
  assign wrCntLow   = wrTake & globHit & (hostAddr == ougc_pkg::OFS_TIMER_LOW);
  assign wrCntHigh  = wrTake & globHit & (hostAddr == ougc_pkg::OFS_TIMER_HIGH);
  assign wrSoftRst  = wrTake & globHit & (hostAddr == ougc_pkg::OFS_SOFT_RST);
  assign wrTimerCmd = wrTake & globHit & (hostAddr == ougc_pkg::OFS_TIMER_CMD);
  assign rdTimerCmd = rdTake & globHit & (hostAddr == ougc_pkg::OFS_TIMER_CMD);

  // Next values of the control registers; other bytes of the window hold none
  assign sample8x_next = wr8x ? hostWrData : sample8x_reg;
  assign sample4x_next = wr4x ? hostWrData : sample4x_reg;
  assign sleepEn_next  = wrSleep ? hostWrData : sleepEn_reg;
  assign bcast_next    = wrBcast ? hostWrData[0] : bcast_reg;
  assign count_next    = {wrCntHigh ? hostWrData : count_reg[15:8],
                          wrCntLow  ? hostWrData : count_reg[7:0]};
  // Pulses last one cycle, then fall back to zero
  assign softRst_next  = wrSoftRst ? hostWrData : ougc_pkg::RST_BYTE;
  assign tCmd_next     = wrTimerCmd ? hostWrData[3:0] : tCmd_reg;
  assign tCmdValid_next = wrTimerCmd;

  // Timer mask follows the enable and disable commands only
  assign timerIrqEn_next = (wrTimerCmd && hostWrData[3:0] == ougc_pkg::TCMD_IRQ_ON)  ? 1'b1 :
                           (wrTimerCmd && hostWrData[3:0] == ougc_pkg::TCMD_IRQ_OFF) ? 1'b0 :
                           timerIrqEn_reg;

  // Time-out arriving with a read of the command register still counts
  assign timerPend_next = (timerTimeout & timerIrqEn_reg) |
                          (timerPend_reg & ~rdTimerCmd);

  // Remember that the whole device went to sleep; the first wake ends it
  wire logic allAsleepNow;
  assign allAsleepNow  = (&chanAsleep) & (sleepEn_reg == ougc_pkg::SLEEP_ALL);
  assign allSlept_next = allAsleepNow ? 1'b1 : ((|chanWake) ? 1'b0 : allSlept_reg);

  // Channel access: reads go to the addressed core, writes may fan out
  assign chanOffset   = hostAddr[3:0];
  assign chanWrData   = hostWrData;
  assign chanRdStrobe = (rdTake & chanHit) ? chanOneHot : 8'h00;
  assign chanWrStrobe = (wrTake & chanHit) ? (bcast_reg ? 8'hFF : chanOneHot) : 8'h00;

  // Reading a channel's status register retires its wake-up indicator
  wire logic [7:0] isrRead;
  assign isrRead = (chanOffset == ougc_pkg::CH_OFS_IRQ_STATUS) ? chanRdStrobe : 8'h00;

  // Per-channel interrupt aggregation
  genvar gi;
  for (gi = 0; gi < NUM_CHAN; gi++) begin : gChan
    wire logic [3:0] srcLive;                 // Enabled pending sources
    wire logic [2:0] code;                    // Highest-priority code
    wire logic       timerHere;               // Timer lands on channel 0 only
    wire logic       wakeSet;                 // Qualified wake-up event

    // Channel enables gate every source the core reports
    assign srcLive = chanSrcPend[gi*4 +: 4] & chanSrcEnable[gi*4 +: 4];
    assign timerHere = (gi == 0) ? timerPend_reg : 1'b0;
    // Priority: rx first, timer last; wake-up shows code zero
    assign code = srcLive[ougc_pkg::SRC_RX]       ? ougc_pkg::CODE_RX :
                  srcLive[ougc_pkg::SRC_RX_TMO]   ? ougc_pkg::CODE_RX_TMO :
                  srcLive[ougc_pkg::SRC_TX_EMPTY] ? ougc_pkg::CODE_TX_EMPTY :
                  srcLive[ougc_pkg::SRC_MODEM]    ? ougc_pkg::CODE_MODEM :
                  timerHere                       ? ougc_pkg::CODE_TIMER :
                  ougc_pkg::CODE_NONE;

    // Wake-up counts only after all channels slept and when this one may sleep
    assign wakeSet = chanWake[gi] & allSlept_reg & sleepEn_reg[gi];
    // Set wins over the clear of a simultaneous status read
    assign wakePend_next[gi] = wakeSet | (wakePend_reg[gi] & ~isrRead[gi]);

    // Summary follows live state, so servicing reads clear it one cycle after the pending bit clears
    assign summary_next[gi] = (|srcLive) | timerHere | wakePend_reg[gi];
    assign codes_next[gi*3 +: 3] = code;
  end

  // Read data selection
  wire logic [7:0] chanRdSel;                 // Addressed channel byte
  wire logic [7:0] globRdSel;                 // Addressed global byte
  assign chanRdSel = chanRdData[chanIdx*8 +: 8];

  assign globRdSel =
    (hostAddr == ougc_pkg::OFS_SUMMARY)    ? summary_reg :
    (hostAddr == ougc_pkg::OFS_CODES_LOW)  ? codes_reg[7:0] :
    (hostAddr == ougc_pkg::OFS_CODES_MID)  ? codes_reg[15:8] :
    (hostAddr == ougc_pkg::OFS_CODES_HIGH) ? codes_reg[23:16] :
    (hostAddr == ougc_pkg::OFS_TIMER_CMD)  ?
      (timerPend_reg ? ougc_pkg::TIMER_PEND_RD : ougc_pkg::RST_BYTE) :
    (hostAddr == ougc_pkg::OFS_TIMER_RSVD) ? ougc_pkg::RST_BYTE :
    (hostAddr == ougc_pkg::OFS_TIMER_LOW)  ? count_reg[7:0] :
    (hostAddr == ougc_pkg::OFS_TIMER_HIGH) ? count_reg[15:8] :
    (hostAddr == ougc_pkg::OFS_SAMPLE_8X)  ? sample8x_reg :
    (hostAddr == ougc_pkg::OFS_SAMPLE_4X)  ? sample4x_reg :
    (hostAddr == ougc_pkg::OFS_SLEEP_EN)   ? sleepEn_reg :
    (hostAddr == ougc_pkg::OFS_REVISION)   ? REVISION :
    (hostAddr == ougc_pkg::OFS_PART_ID)    ? PART_ID :
    (hostAddr == ougc_pkg::OFS_BCAST)      ? {7'h00, bcast_reg} :
    ougc_pkg::RST_BYTE;                       // Soft reset and 0x8F read zero

  // Hold last read data between reads; unmapped space reads zero
  assign rdData_next = ~rdTake ? rdData_reg :
                       chanHit ? chanRdSel :
                       globHit ? globRdSel :
                       ougc_pkg::RST_BYTE;

  // Configuration flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sample8x_reg <= ougc_pkg::RST_BYTE;
      sample4x_reg <= ougc_pkg::RST_BYTE;
      sleepEn_reg  <= ougc_pkg::RST_BYTE;
      bcast_reg    <= 1'b0;
      count_reg    <= ougc_pkg::RST_COUNT;
    end else begin
      sample8x_reg <= sample8x_next;
      sample4x_reg <= sample4x_next;
      sleepEn_reg  <= sleepEn_next;
      bcast_reg    <= bcast_next;
      count_reg    <= count_next;
    end
  end

  // Command and pulse flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      softRst_reg    <= ougc_pkg::RST_BYTE;
      tCmd_reg       <= 4'h0;
      tCmdValid_reg  <= 1'b0;
      timerIrqEn_reg <= 1'b0;
    end else begin
      softRst_reg    <= softRst_next;
      tCmd_reg       <= tCmd_next;
      tCmdValid_reg  <= tCmdValid_next;
      timerIrqEn_reg <= timerIrqEn_next;
    end
  end

  // Interrupt state flops, all clear at reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timerPend_reg <= 1'b0;
      allSlept_reg  <= 1'b0;
      wakePend_reg  <= ougc_pkg::RST_BYTE;
      summary_reg   <= ougc_pkg::RST_BYTE;
      codes_reg     <= 24'h000000;
    end else begin
      timerPend_reg <= timerPend_next;
      allSlept_reg  <= allSlept_next;
      wakePend_reg  <= wakePend_next;
      summary_reg   <= summary_next;
      codes_reg     <= codes_next;
    end
  end

  // Read return flop
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rdData_reg <= ougc_pkg::RST_BYTE;
    end else begin
      rdData_reg <= rdData_next;
    end
  end

  // Outputs
  assign hostRdData      = rdData_reg;
  assign chanSample8x    = sample8x_reg;
  assign chanSample4x    = sample4x_reg;
  // Neither select leaves the channel at 16x
  assign chanSample16x   = ~(sample8x_reg | sample4x_reg);
  assign chanSoftReset   = softRst_reg;
  assign chanSleepEnable = sleepEn_reg;
  assign timerCmd        = tCmd_reg;
  assign timerCmdValid   = tCmdValid_reg;
  assign timerCount      = count_reg;

endmodule : ougc_regs
`default_nettype wire

/* bench/ougc_regs_asserts.sv */
`default_nettype none
module ougc_regs_asserts #(
  parameter int unsigned NUM_CHAN = 8
) (
  input wire logic                  clk_sys,
  input wire logic                  rst_n,
  input wire logic                  hostCs,
  input wire logic                  hostRd,
  input wire logic                  hostWr,
  input wire logic [7:0]            hostAddr,
  input wire logic [7:0]            hostWrData,
  input wire logic [7:0]            hostRdData,
  input wire logic [3:0]            chanOffset,
  input wire logic [7:0]            chanWrData,
  input wire logic [NUM_CHAN-1:0]   chanWrStrobe,
  input wire logic [NUM_CHAN-1:0]   chanRdStrobe,
  input wire logic [NUM_CHAN*8-1:0] chanRdData,
  input wire logic [NUM_CHAN-1:0]   chanSample8x,
  input wire logic [NUM_CHAN-1:0]   chanSample4x,
  input wire logic [NUM_CHAN-1:0]   chanSample16x,
  input wire logic [NUM_CHAN-1:0]   chanSoftReset,
  input wire logic [NUM_CHAN-1:0]   chanSleepEnable,
  input wire logic [3:0]            timerCmd,
  input wire logic                  timerCmdValid,
  input wire logic [15:0]           timerCount
);
  timeunit 1ns;
  timeprecision 1ps;
  // Decoded host cycles, watched only, never driven
  wire logic       rdCyc   = hostCs && hostRd;
  wire logic       wrCyc   = hostCs && hostWr;
  // Byte the addressed channel offers right now
  wire logic [7:0] selByte = chanRdData[hostAddr[6:4]*8 +: 8];
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_CHAN_READ: assert property (rdCyc && !hostAddr[7] |=> hostRdData == $past(selByte))
    else $error("channel read data not returned");
  AST_RD_STROBE: assert property (rdCyc && !hostAddr[7] |->
    chanRdStrobe == (8'h01 << hostAddr[6:4]))
    else $error("read strobe on wrong channel");
  AST_WR_STROBE: assert property (wrCyc && !hostAddr[7] |-> chanWrStrobe[hostAddr[6:4]])
    else $error("write strobe missing");
  AST_NO_STROBE: assert property (!(wrCyc && !hostAddr[7]) |-> chanWrStrobe == 8'h00)
    else $error("write strobe outside channel space");
  AST_PASS_THRU: assert property (chanOffset == hostAddr[3:0] && chanWrData == hostWrData)
    else $error("offset or data not passed to channels");
  AST_SAMPLE16: assert property (chanSample16x == ~(chanSample8x | chanSample4x))
    else $error("16x select not the default");
  // Pulse falls after one cycle unless a back-to-back write renews it
  AST_SOFT_RST: assert property (wrCyc && hostAddr == 8'h8A |=>
    chanSoftReset == $past(hostWrData) ##1
    (chanSoftReset == 8'h00 || $past(wrCyc && hostAddr == 8'h8A)))
    else $error("soft reset pulse wrong");
  AST_SLEEP_EN: assert property (wrCyc && hostAddr == 8'h8B |=>
    chanSleepEnable == $past(hostWrData))
    else $error("sleep enable not updated");
  AST_TIMER_CMD: assert property (wrCyc && hostAddr == 8'h84 |=>
    timerCmdValid && timerCmd == $past(hostWrData[3:0]))
    else $error("timer command not issued");
  AST_COUNT_LOW: assert property (wrCyc && hostAddr == 8'h86 |=>
    timerCount[7:0] == $past(hostWrData))
    else $error("timer count low byte wrong");
  AST_HIGH_ZERO: assert property (rdCyc && hostAddr >= 8'h8F |=> hostRdData == 8'h00)
    else $error("unassigned address read not zero");
endmodule : ougc_regs_asserts
bind ougc_regs ougc_regs_asserts #(.NUM_CHAN(NUM_CHAN)) ougc_regs_asserts_i (
  .clk_sys(clk_sys), .rst_n(rst_n), .hostCs(hostCs), .hostRd(hostRd), .hostWr(hostWr),
  .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
  .chanOffset(chanOffset), .chanWrData(chanWrData), .chanWrStrobe(chanWrStrobe),
  .chanRdStrobe(chanRdStrobe), .chanRdData(chanRdData), .chanSample8x(chanSample8x),
  .chanSample4x(chanSample4x), .chanSample16x(chanSample16x), .chanSoftReset(chanSoftReset),
  .chanSleepEnable(chanSleepEnable), .timerCmd(timerCmd), .timerCmdValid(timerCmdValid),
  .timerCount(timerCount));
`default_nettype wire

/* bench/ougc_chan_model.sv */
`default_nettype none
module ougc_chan_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [3:0]  chanOffset,
  input  wire logic [7:0]  chanWrData,
  input  wire logic [7:0]  chanWrStrobe,
  output logic      [63:0] chanRdData
);
  timeunit 1ns;
  timeprecision 1ps;
  // Sixteen plain bytes per channel; no side effects, so read-back is exact
  logic [7:0] memReg [8][16];
  // Each channel answers for the current offset, selected or not
  always_comb begin
    for (int n = 0; n < 8; n++) chanRdData[n*8 +: 8] = memReg[n][chanOffset];
  end
  // Store on strobe; several strobes at once is the broadcast case
  always_ff @(posedge clk_sys or negedge rst_n) begin
    for (int n = 0; n < 8; n++) begin
      for (int k = 0; k < 16; k++) begin
        if (!rst_n) memReg[n][k] <= 8'h00;
        else if (chanWrStrobe[n] && chanOffset == k[3:0]) memReg[n][k] <= chanWrData;
      end
    end
  end
endmodule : ougc_chan_model
`default_nettype wire

/* bench/testbench.sv */
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] REV_VAL = 8'h3C;  // Arbitrary revision value
  localparam logic [7:0] PID_VAL = 8'hC3;  // Arbitrary identification value
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        hostCs = 1'b0, hostRd = 1'b0, hostWr = 1'b0;
  logic [7:0]  hostAddr = 8'h00, hostWrData = 8'h00, hostRdData;
  logic [3:0]  chanOffset, timerCmd;
  logic [7:0]  chanWrData, chanWrStrobe, chanRdStrobe, chanSample8x, chanSample4x;
  logic [7:0]  chanSample16x, chanSoftReset, chanSleepEnable;
  logic [63:0] chanRdData;
  logic [31:0] chanSrcPend = 32'h0, chanSrcEnable = 32'h0;
  logic [7:0]  chanAsleep = 8'h00, chanWake = 8'h00;
  logic        timerCmdValid, timerTimeout = 1'b0;
  logic [15:0] timerCount;
  logic [7:0]  expSum;
  logic [23:0] expCodes;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  always #2.5 clk_sys = ~clk_sys;
  ougc_regs #(.NUM_CHAN(8), .REVISION(REV_VAL), .PART_ID(PID_VAL)) ougc_regs_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .hostCs(hostCs), .hostRd(hostRd), .hostWr(hostWr),
    .hostAddr(hostAddr), .hostWrData(hostWrData), .hostRdData(hostRdData),
    .chanOffset(chanOffset), .chanWrData(chanWrData), .chanWrStrobe(chanWrStrobe),
    .chanRdStrobe(chanRdStrobe), .chanRdData(chanRdData), .chanSrcPend(chanSrcPend),
    .chanSrcEnable(chanSrcEnable), .chanAsleep(chanAsleep), .chanWake(chanWake),
    .chanSample8x(chanSample8x), .chanSample4x(chanSample4x), .chanSample16x(chanSample16x),
    .chanSoftReset(chanSoftReset), .chanSleepEnable(chanSleepEnable), .timerCmd(timerCmd),
    .timerCmdValid(timerCmdValid), .timerCount(timerCount), .timerTimeout(timerTimeout));
  ougc_chan_model ougc_chan_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .chanOffset(chanOffset), .chanWrData(chanWrData),
    .chanWrStrobe(chanWrStrobe), .chanRdData(chanRdData));
  // Highest-priority source among the enabled ones
  function automatic logic [2:0] topCode(input logic [3:0] p);
    if (p[0]) return ougc_pkg::CODE_RX;
    if (p[1]) return ougc_pkg::CODE_RX_TMO;
    if (p[2]) return ougc_pkg::CODE_TX_EMPTY;
    if (p[3]) return ougc_pkg::CODE_MODEM;
    return ougc_pkg::CODE_NONE;
  endfunction : topCode
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (exp !== got) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // One-cycle host access; request held until the taking edge
  task automatic hostCycle(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    hostCs <= 1'b1; hostRd <= !wr; hostWr <= wr; hostAddr <= a; hostWrData <= d;
    @(posedge clk_sys);
    hostCs <= 1'b0; hostRd <= 1'b0; hostWr <= 1'b0;
    #1;
  endtask : hostCycle
  task automatic wr8(input logic [7:0] a, input logic [7:0] d);
    hostCycle(1'b1, a, d);
  endtask : wr8
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    hostCycle(1'b0, a, 8'h00);
    chk($sformatf("read 0x%h", a), {8'h00, exp}, {8'h00, hostRdData});
  endtask : rdChk
  // Hold the state inputs steady long enough for the registered images
  task automatic settle();
    repeat (3) @(posedge clk_sys);
  endtask : settle
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  // Hang guard: the whole sequence needs well under this
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    for (int a = 8'h80; a <= 8'h85; a++) rdChk(a[7:0], 8'h00);
    $display("Test reset values done");
    wr8(8'h86, 8'h5C); wr8(8'h87, 8'hA3); wr8(8'h88, 8'h0F); wr8(8'h89, 8'h30);
    wr8(8'h8B, 8'h81); wr8(8'h8C, 8'hFF); wr8(8'h8D, 8'hFF); wr8(8'h8F, 8'hFF);
    wr8(8'h8A, 8'h24); wr8(8'h84, 8'h04); wr8(8'h81, 8'hFF);
    chk("timer count", 16'hA35C, timerCount);
    chk("16x select", {8'h00, 8'hC0}, {8'h00, chanSample16x});
    chk("8x 4x select", 16'h0F30, {chanSample8x, chanSample4x});
    chk("sleep enable", 16'h0081, {8'h00, chanSleepEnable});
    rdChk(8'h86, 8'h5C); rdChk(8'h87, 8'hA3);
    rdChk(8'h88, 8'h0F); rdChk(8'h89, 8'h30);
    rdChk(8'h8B, 8'h81); rdChk(8'h8A, 8'h00); rdChk(8'h81, 8'h00);
    rdChk(8'h8C, REV_VAL); rdChk(8'h8D, PID_VAL); rdChk(8'h8F, 8'h00);
    rdChk(8'h84, 8'h00); rdChk(8'h90, 8'h00); rdChk(8'hFF, 8'h00);
    $display("Test global registers done");
    for (int n = 0; n < 8; n++) wr8({n[2:0] + 4'h0, 4'hF} & 8'h7F, 8'h10 + n[7:0]);
    for (int n = 0; n < 8; n++) rdChk({1'b0, n[2:0], 4'hF}, 8'h10 + n[7:0]);
    wr8(8'h8E, 8'hFF); rdChk(8'h8E, 8'h01);
    wr8(8'h34, 8'hA5); wr8(8'h8E, 8'h00);
    for (int n = 0; n < 8; n++) rdChk({1'b0, n[2:0], 4'h4}, 8'hA5);
    wr8(8'h24, 8'h6E); rdChk(8'h24, 8'h6E); rdChk(8'h44, 8'hA5);
    $display("Test channel windows done");
    for (int pass = 0; pass < 2; pass++) begin
      @(posedge clk_sys);
      chanSrcPend <= 32'h84C2_1A63;
      chanSrcEnable <= pass == 0 ? 32'hFFFF_FFFF : 32'h0F0F_F0F0;
      settle();
      for (int n = 0; n < 8; n++) begin
        expSum[n] = |(chanSrcPend[n*4 +: 4] & chanSrcEnable[n*4 +: 4]);
        expCodes[n*3 +: 3] = topCode(chanSrcPend[n*4 +: 4] & chanSrcEnable[n*4 +: 4]);
      end
      rdChk(8'h80, expSum);
      rdChk(8'h81, expCodes[7:0]); rdChk(8'h82, expCodes[15:8]);
      rdChk(8'h83, expCodes[23:16]);
    end
    @(posedge clk_sys);
    chanSrcPend <= 32'h0;
    settle();
    rdChk(8'h80, 8'h00);
    $display("Test interrupt sources done");
    @(posedge clk_sys) timerTimeout <= 1'b1;
    @(posedge clk_sys) timerTimeout <= 1'b0;
    rdChk(8'h84, 8'h00); rdChk(8'h80, 8'h00);
    wr8(8'h84, 8'h01);
    @(posedge clk_sys) timerTimeout <= 1'b1;
    @(posedge clk_sys) timerTimeout <= 1'b0;
    settle();
    rdChk(8'h80, 8'h01); rdChk(8'h81, 8'h07);
    rdChk(8'h84, 8'h01); rdChk(8'h84, 8'h00);
    wr8(8'h84, 8'h02);
    $display("Test timer interrupt done");
    for (int pass = 0; pass < 2; pass++) begin
      wr8(8'h8B, 8'hFF);
      @(posedge clk_sys) chanAsleep <= pass == 0 ? 8'hFF : 8'h7F;
      settle();
      // The waking channel leaves sleep in the same cycle as its pulse
      chanWake <= 8'h20;
      chanAsleep <= 8'h00;
      @(posedge clk_sys) chanWake <= 8'h00;
      settle();
      rdChk(8'h80, pass == 0 ? 8'h20 : 8'h00); rdChk(8'h82, 8'h00);
      rdChk(8'h52, 8'h00); settle(); rdChk(8'h80, 8'h00);
    end
    $display("Test sleep wake-up done");
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
